/* rtl/cprs_clock_rate_select.sv */
`timescale 1ns/1ps
// Behaviour
// - double speed bit 0 gives 12 periods per cycle, cpu and peripheral enables at half rate
// - double speed bit 1 gives 6 periods per cycle, cpu and peripheral enables every oscillator cycle
// - timer0 and spi half-rate bits matter only while double speed is set
// - in doubled mode, bit 0 gives 6 periods, bit 1 gives 12 per peripheral cycle
// - double speed at bit 0, timer0 at bit 1; spi bit at bit 0 of second register
// - both clock control registers clear to zero on reset
// - bits 7 to 1 of the spi control register always read zero
module cprs_clock_rate_select
  import cprs_pkg::*;
(
  input  wire logic              i_clk,          // oscillator clock
  input  wire logic              i_rst,          // sync reset, active high
  input  wire logic              i_ce,           // clock enable, freezes state when low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,   // write address
  input  wire logic              s_axi_awvalid,  // write address valid
  output logic                   s_axi_awready,  // write address ready
  input  wire logic [31:0]       s_axi_wdata,    // write data
  input  wire logic [3:0]        s_axi_wstrb,    // write strobes
  input  wire logic              s_axi_wvalid,   // write data valid
  output logic                   s_axi_wready,   // write data ready
  output logic [1:0]             s_axi_bresp,    // write response
  output logic                   s_axi_bvalid,   // write response valid
  input  wire logic              s_axi_bready,   // write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
  input  wire logic              s_axi_arvalid,  // read address valid
  output logic                   s_axi_arready,  // read address ready
  output logic [31:0]            s_axi_rdata,    // read data
  output logic [1:0]             s_axi_rresp,    // read response
  output logic                   s_axi_rvalid,   // read data valid
  input  wire logic              s_axi_rready,   // read data ready
  output cprs_enables_t          o_clk_en,       // clock enable pulses
  output logic [3:0]             o_cycle_periods // oscillator periods per machine cycle
);

  localparam int EN_W = $bits(cprs_enables_t);

  logic [7:0]        sys_clk_ctrl;
  logic [7:0]        spi_clk_ctrl;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic              w_lane0;
  logic              phase;

  // address decode shared by both channels
  function automatic logic [1:0] dec(input logic [ADDR_W-1:0] a);
    dec = {a == SPI_CLK_CTRL_ADDR, a == SYS_CLK_CTRL_ADDR};
  endfunction

  // channel handshakes; an item moves only where valid and ready meet at an edge
  // every slave output is registered, so each answer lands one edge after its cause
  wire       aw_take   = s_axi_awvalid && s_axi_awready;
  wire       w_take    = s_axi_wvalid && s_axi_wready;
  wire       b_done    = s_axi_bvalid && s_axi_bready;
  wire       take_read = s_axi_arvalid && s_axi_arready;
  wire       r_done    = s_axi_rvalid && s_axi_rready;

  // write channel: take address and data in either order, answer once both are held
  wire       do_write   = aw_held && w_held && !s_axi_bvalid;
  wire [1:0] w_hit      = dec(aw_addr);
  wire       w_mapped   = |w_hit;
  wire [1:0] next_bresp = w_mapped ? RESP_OKAY : RESP_SLVERR;

  // ready falls right after a take, so a held item is never overwritten
  wire       next_awready = !aw_held && !aw_take;
  wire       next_wready  = !w_held && !w_take;

  // register strobes; a write without lane 0 stores nothing yet still answers okay
  wire       wr_sys        = do_write && w_lane0 && w_hit[0];
  wire       wr_spi        = do_write && w_lane0 && w_hit[1];
  wire [7:0] next_spi_ctrl = w_data[7:0] & SPI_CTRL_MASK;

  // read data selection; reserved spi bits are masked once more on the way out
  wire [1:0] r_hit        = dec(s_axi_araddr);
  wire [7:0] rd_sys_sel   = r_hit[0] ? sys_clk_ctrl : 8'h00;
  wire [7:0] rd_spi_sel   = r_hit[1] ? (spi_clk_ctrl & SPI_CTRL_MASK) : 8'h00;
  wire [7:0] rd_byte      = rd_sys_sel | rd_spi_sel;
  wire [1:0] next_rresp   = (|r_hit) ? RESP_OKAY : RESP_SLVERR;
  wire       next_arready = !s_axi_rvalid && !take_read;

  // control bits
  wire double_speed_select            = sys_clk_ctrl[DOUBLE_SPEED_BIT];
  wire timer0_half_rate_select        = sys_clk_ctrl[TIMER0_HALF_BIT];
  wire serial_periph_half_rate_select = spi_clk_ctrl[SPI_HALF_BIT];
  wire standard_speed_mode            = !double_speed_select;

  // half rate applies in standard mode; per-unit bits only count in doubled mode
  wire cpu_half    = standard_speed_mode;
  wire timer0_half = standard_speed_mode || timer0_half_rate_select;
  wire spi_half    = standard_speed_mode || serial_periph_half_rate_select;

  // enable pulse: every cycle at full rate, on phase high at half rate
  // one slot per unit in struct order cpu, periph, timer0, spi; periph follows the cpu
  wire [EN_W-1:0] unit_half    = {cpu_half, cpu_half, timer0_half, spi_half};
  wire [EN_W-1:0] next_en_vec;
  wire [3:0]      next_periods = standard_speed_mode ? STD_PERIODS : DBL_PERIODS;

  // same pulse rule for every unit, so one generate loop covers all of them
  genvar g;
  generate
    for (g = 0; g < EN_W; g = g + 1) begin : g_unit_en
      assign next_en_vec[g] = !unit_half[g] || phase;
    end
  endgenerate

  // write address holder; awready is low while it is full
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (i_ce) begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  // write data holder; only lane 0 carries a register byte
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_lane0 <= 1'b0;
    end else if (i_ce) begin
      if (w_take) begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response; do_write waits for the last one to drain, so raise and drop never meet
  // bresp is set with bvalid and holds until the master takes it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (i_ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= next_bresp;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ready outputs registered: low while the channel holds an item
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (i_ce) begin
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
    end
  end

  // control registers; reserved spi bits are never stored
  // the system register keeps all eight bits, only the low two steer the clocks
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sys_clk_ctrl <= CLK_CTRL_RESET;
      spi_clk_ctrl <= CLK_CTRL_RESET;
    end else if (i_ce) begin
      if (wr_sys) begin
        sys_clk_ctrl <= w_data[7:0];
      end
      if (wr_spi) begin
        spi_clk_ctrl <= next_spi_ctrl;
      end
    end
  end

  // read channel: one read at a time, answered the cycle after it is taken
  // rdata and rresp stand unchanged until rready, the next take cannot start before
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (i_ce) begin
      s_axi_arready <= next_arready;
      if (take_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= next_rresp;
        s_axi_rdata  <= {24'h000000, rd_byte};
      end else if (r_done) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // half-rate phase; one shared toggle keeps all half-rate units in step
  // limitation: there is no per-unit phase offset between half-rate units
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase <= 1'b0;
    end else if (i_ce) begin
      phase <= !phase;
    end
  end

  // registered enables and cycle length; enables instead of divided clocks avoid new domains
  // periph pulse is the cpu pulse; both follow only the global speed bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_clk_en        <= '0;
      o_cycle_periods <= STD_PERIODS;
    end else if (i_ce) begin
      o_clk_en        <= cprs_enables_t'(next_en_vec);
      o_cycle_periods <= next_periods;
    end
  end

endmodule

/* rtl/cprs_pkg.sv */
package cprs_pkg;
  // register byte addresses; the spi register is placed by word index, scaled by four
  localparam logic [7:0]  SPI_CLK_CTRL_IDX = 8'hAF;
  localparam logic [11:0] SPI_CLK_CTRL_ADDR = {2'h0, SPI_CLK_CTRL_IDX, 2'h0};
  localparam logic [11:0] SYS_CLK_CTRL_ADDR = 12'h000;
  localparam int          ADDR_W            = 12;
  // field positions
  localparam int DOUBLE_SPEED_BIT  = 0;
  localparam int TIMER0_HALF_BIT   = 1;
  localparam int SPI_HALF_BIT      = 0;
  // reset values and masks
  localparam logic [7:0] CLK_CTRL_RESET = 8'h00;
  localparam logic [7:0] SPI_CTRL_MASK  = 8'h01;
  // oscillator periods per machine cycle
  localparam logic [3:0] STD_PERIODS = 4'hC;
  localparam logic [3:0] DBL_PERIODS = 4'h6;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic cpu_en;
    logic periph_en;
    logic timer0_en;
    logic spi_en;
  } cprs_enables_t;
endpackage

/* tb/cprs_monitor.sv */
`timescale 1ns/1ps
module cprs_monitor
  import cprs_pkg::*;
(
  input wire logic              i_clk,          // clock
  input wire logic              i_rst,          // sync reset
  input wire logic              i_ce,           // clock enable
  input wire logic [ADDR_W-1:0] s_axi_araddr,   // read address
  input wire logic              s_axi_arvalid,  // ar valid
  input wire logic              s_axi_arready,  // ar ready
  input wire logic [31:0]       s_axi_rdata,    // read data
  input wire logic              s_axi_rvalid,   // r valid
  input wire logic              s_axi_bvalid,   // b valid
  input wire cprs_enables_t     o_clk_en,       // enables
  input wire logic [3:0]        o_cycle_periods // periods
);
  logic [1:0] age;
  logic       rd_spi;
  wire        live   = age == 2'h3 && i_ce;
  wire        in_std = live && o_cycle_periods == STD_PERIODS;
  wire        in_dbl = live && o_cycle_periods == DBL_PERIODS;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // enables start late after reset, so hold off; remember which register a read hit
  always_ff @(posedge i_clk) age <= (i_rst || !i_ce) ? 2'h0 : age + {1'b0, !live};
  always_ff @(posedge i_clk) if (s_axi_arvalid && s_axi_arready) rd_spi <= s_axi_araddr == SPI_CLK_CTRL_ADDR;
  AST_STD_HALF: assert property (in_std [*4] |-> o_clk_en.cpu_en != $past(o_clk_en.cpu_en))
    else $error("cpu enable not half rate");
  AST_DBL_FULL: assert property (in_dbl [*4] |-> o_clk_en.cpu_en && o_clk_en.periph_en)
    else $error("cpu enable not full rate");
  AST_STD_LOCK: assert property (in_std [*4] |-> {2{o_clk_en.cpu_en}} == {o_clk_en.timer0_en, o_clk_en.spi_en})
    else $error("override bit acted in standard mode");
  AST_T0_GAP: assert property (live && !o_clk_en.timer0_en |=> o_clk_en.timer0_en)
    else $error("timer0 enable slower than half rate");
  AST_SPI_GAP: assert property (live && !o_clk_en.spi_en |=> o_clk_en.spi_en)
    else $error("spi enable slower than half rate");
  AST_RESET_VAL: assert property ($fell(i_rst) |-> o_cycle_periods == STD_PERIODS && o_clk_en == 4'h0)
    else $error("bad outputs after reset");
  AST_SPI_RSVD: assert property (s_axi_rvalid && rd_spi |-> s_axi_rdata[31:1] == 31'h0)
    else $error("reserved spi bits read nonzero");
  // a mode change must trace back to a write response
  AST_MODE_WRITE: assert property (live && $changed(o_cycle_periods) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("mode changed without a write");
  // a low clock enable must freeze the enable and cycle period outputs
  AST_CE_HOLD: assert property (!i_ce |=> $stable(o_clk_en) && $stable(o_cycle_periods))
    else $error("outputs moved while clock enable low");
  cover property (!i_ce ##1 i_ce);
  cover property (in_dbl [*4]);
  cover property (in_std [*4] ##1 o_clk_en.cpu_en);
  cover property (s_axi_rvalid && rd_spi);
endmodule
bind cprs_clock_rate_select cprs_monitor u_mon (.*);

/* tb/cpu_peripheral_clock_rate_select_tb.sv */
`timescale 1ns/1ps
module cpu_peripheral_clock_rate_select_tb import cprs_pkg::*;;
  logic              i_clk, i_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        o_cycle_periods;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  cprs_enables_t     o_clk_en;
  int                errors, comparisons, cyc;
  logic              i_ce;
  logic [3:0]        s_axi_wstrb;
  cprs_clock_rate_select u_dut (.*);
  // oscillator
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // hang guard, run needs under two hundred cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, what);
    end
  endtask
  task automatic restart;
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
  endtask
  // one write (w=1) or read; each channel released only at its own handshake
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [1:0] er,
                      input logic [7:0] ed);
    logic ad, wd;
    ad = 1'b0;
    wd = !w;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    while (!(ad && wd)) begin
      @(posedge i_clk);
      if (!ad && (w ? s_axi_awready : s_axi_arready)) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge i_clk); while ((w ? s_axi_bvalid : s_axi_rvalid) !== 1'b1);
    check((w ? s_axi_bresp : s_axi_rresp) === er && (w || s_axi_rdata === {24'h0, ed}), "bus answer");
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  // two samples: full-rate enables high in both, half-rate in exactly one
  task automatic en(input logic [3:0] ep, input logic [3:0] full);
    cprs_enables_t a;
    repeat (4) @(posedge i_clk);
    a = o_clk_en;
    @(posedge i_clk);
    check(o_cycle_periods === ep && (a & o_clk_en) === full && (a | o_clk_en) === 4'hF, "enable pattern");
  endtask
  // clock enable low: an odd number of frozen edges would move any half-rate enable
  task automatic freeze;
    cprs_enables_t a;
    logic [3:0]    p;
    i_ce <= 1'b0;
    repeat (2) @(posedge i_clk);
    a = o_clk_en;
    p = o_cycle_periods;
    repeat (3) @(posedge i_clk);
    check(o_clk_en === a && o_cycle_periods === p, "frozen outputs");
    i_ce <= 1'b1;
    @(posedge i_clk);
  endtask
  initial begin
    {i_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    {i_ce, s_axi_wstrb} = 5'h1F;
    restart();
    xfer(0, SYS_CLK_CTRL_ADDR, 8'h00, RESP_OKAY, 8'h00);
    xfer(0, SPI_CLK_CTRL_ADDR, 8'h00, RESP_OKAY, 8'h00);
    en(STD_PERIODS, 4'h0);
    $display("reset test done");
    xfer(1, SYS_CLK_CTRL_ADDR, 8'h03, RESP_OKAY, 8'h00);
    en(DBL_PERIODS, 4'hD);
    freeze();
    en(DBL_PERIODS, 4'hD);
    xfer(1, SPI_CLK_CTRL_ADDR, 8'h01, RESP_OKAY, 8'h00);
    xfer(0, SPI_CLK_CTRL_ADDR, 8'h00, RESP_OKAY, 8'h01);
    en(DBL_PERIODS, 4'hC);
    xfer(1, SYS_CLK_CTRL_ADDR, 8'h01, RESP_OKAY, 8'h00);
    en(DBL_PERIODS, 4'hE);
    xfer(1, SPI_CLK_CTRL_ADDR, 8'h00, RESP_OKAY, 8'h00);
    en(DBL_PERIODS, 4'hF);
    $display("doubled mode test done");
    xfer(1, SPI_CLK_CTRL_ADDR, 8'h01, RESP_OKAY, 8'h00);
    xfer(1, SYS_CLK_CTRL_ADDR, 8'h02, RESP_OKAY, 8'h00);
    en(STD_PERIODS, 4'h0);
    xfer(1, 12'h004, 8'h01, RESP_SLVERR, 8'h00);
    xfer(0, 12'h004, 8'h00, RESP_SLVERR, 8'h00);
    xfer(0, SYS_CLK_CTRL_ADDR, 8'h00, RESP_OKAY, 8'h02);
    s_axi_wstrb <= 4'h0;
    xfer(1, SYS_CLK_CTRL_ADDR, 8'h01, RESP_OKAY, 8'h00);
    s_axi_wstrb <= 4'hF;
    xfer(0, SYS_CLK_CTRL_ADDR, 8'h00, RESP_OKAY, 8'h02);
    restart();
    xfer(0, SYS_CLK_CTRL_ADDR, 8'h00, RESP_OKAY, 8'h00);
    en(STD_PERIODS, 4'h0);
    $display("override and error test done");
    print_verdict();
  end
endmodule
